// *** pkg/touch_cfg_pkg.sv ***
// Constants, field layouts and carrier types for the standby touch and lamp configuration block.
// Assumes one 25 MHz clock domain and a register port driven by same-clock serial-port logic.
package touch_cfg_pkg;

  localparam int CH_N = 3;

  // Register offsets
  localparam logic [7:0] ADDR_STANDBY_GAIN = 8'h42;
  localparam logic [7:0] ADDR_STANDBY_THRESH = 8'h43;
  localparam logic [7:0] ADDR_BASELINE_CH1 = 8'h50;
  localparam logic [7:0] ADDR_BASELINE_CH2 = 8'h51;
  localparam logic [7:0] ADDR_BASELINE_CH3 = 8'h52;
  localparam logic [7:0] ADDR_DRIVE_STYLE = 8'h71;
  localparam logic [7:0] ADDR_LAMP_LINK = 8'h72;
  localparam logic [7:0] ADDR_LAMP_POLARITY = 8'h73;

  // Values after reset
  localparam logic [2:0] RST_STANDBY_GAIN = 3'h2;
  localparam logic [6:0] RST_STANDBY_THRESH = 7'h40;
  localparam logic [15:0] RST_BASELINE = 16'h00C8;
  localparam logic [2:0] RST_DRIVE_STYLE = 3'h0;
  localparam logic [2:0] RST_LAMP_LINK = 3'h0;
  localparam logic [2:0] RST_LAMP_POLARITY = 3'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Gain code of the least sensitive (1x) setting; multiplier is 2**(GAIN_CODE_MAX - code)
  localparam logic [2:0] GAIN_CODE_MAX = 3'h7;

  // Recalibration: 256 samples of 16-bit counts into a 24-bit sum
  localparam int ACC_W = 24;
  localparam int COUNT_W = 16;
  localparam logic [7:0] RECAL_LAST = 8'hFF;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic style;
    logic polarity;
    logic actuate;
  } lamp_ctrl_s;

endpackage

// *** hdl/baseline_recal.sv ***
// Per-input recalibration adder that produces the 16-bit untouched baseline.
// Assumes count samples arrive as one-cycle strobes on the block clock.
`timescale 1ns/1ps
`default_nettype none
module baseline_recal
  import touch_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Samples
  input wire logic sample_valid_in,
  input wire logic [COUNT_W-1:0] count_in,
  // Result
  output logic [COUNT_W-1:0] baseline_out
);

  logic [ACC_W-1:0] acc_reg;
  logic [7:0] cnt_reg;
  logic [COUNT_W-1:0] base_reg;
  wire logic [ACC_W-1:0] sum_next = acc_reg + {8'h00, count_in};
  wire logic last_sample = (cnt_reg == RECAL_LAST);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_reg <= '0;
      cnt_reg <= 8'h00;
      base_reg <= RST_BASELINE;
    end else if (sample_valid_in) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (last_sample) begin
        base_reg <= sum_next[ACC_W-1 -: COUNT_W];
        acc_reg <= '0;
      end else begin
        acc_reg <= sum_next;
      end
    end
  end

  assign baseline_out = base_reg;

endmodule
`default_nettype wire

// *** hdl/lamp_pin_driver.sv ***
// Output stage of one lamp pin: polarity, then open-drain or push-pull drive.
// Assumes the pad resolves the level from out and enable; an external pull-up exists.
`timescale 1ns/1ps
`default_nettype none
module lamp_pin_driver
  import touch_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control
  input wire lamp_ctrl_s ctrl_in,
  // Pin
  output logic pin_out,
  output logic pin_oe_out
);

  logic out_reg;
  logic oe_reg;
  // Level wanted at the pin; inverted polarity turns actuation into a low
  wire logic pin_level = ctrl_in.polarity ? ctrl_in.actuate : ~ctrl_in.actuate;
  wire logic out_next = ctrl_in.style ? pin_level : 1'b0;
  wire logic oe_next = ctrl_in.style ? 1'b1 : ~pin_level;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe_out = oe_reg;

endmodule
`default_nettype wire

// *** hdl/touch_standby_led_config.sv ***
// Register slice for standby gain and threshold, baseline counts and lamp routing.
// Assumes the serial-port logic presents requests on the same clock, one per cycle,
// and that sensing logic supplies counts, deltas and active-mode touches on that clock.
`timescale 1ns/1ps
`default_nettype none
module touch_standby_led_config
  import touch_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,

  // Register port from the serial interface
  input wire reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,

  // Sensing state
  input wire logic standby_mode_in,
  input wire logic [CH_N-1:0] standby_enable_in,
  input wire logic [CH_N-1:0] active_touch_in,
  input wire logic [CH_N-1:0] delta_valid_in,
  input wire logic [CH_N*8-1:0] delta_count_in,

  // Recalibration samples
  input wire logic [CH_N-1:0] count_valid_in,
  input wire logic [CH_N*COUNT_W-1:0] count_in,
  input wire logic [3:0] base_shift_in,

  // Host lamp control
  input wire logic [CH_N-1:0] lamp_host_drive_in,

  // Touch result
  output logic [CH_N-1:0] touch_out,

  // Lamp pins
  output logic [CH_N-1:0] lamp_pin_out,
  output logic [CH_N-1:0] lamp_pin_oe_out
);

  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire logic rst_b = rst_sync_reg;

  // Configuration registers
  logic [2:0] standby_gain_code_reg;
  logic [6:0] standby_thresh_reg;
  logic [CH_N-1:0] drive_style_reg;
  logic [CH_N-1:0] lamp_link_reg;
  logic [CH_N-1:0] lamp_polarity_reg;
  logic [7:0] rdata_reg;
  logic [CH_N-1:0] touch_reg;

  // Field aliases
  wire logic lamp1_drive_style = drive_style_reg[0];
  wire logic lamp2_drive_style = drive_style_reg[1];
  wire logic lamp3_drive_style = drive_style_reg[2];
  wire logic link_touch1_lamp1 = lamp_link_reg[0];
  wire logic link_touch2_lamp2 = lamp_link_reg[1];
  wire logic link_touch3_lamp3 = lamp_link_reg[2];
  wire logic lamp1_polarity = lamp_polarity_reg[0];
  wire logic lamp2_polarity = lamp_polarity_reg[1];
  wire logic lamp3_polarity = lamp_polarity_reg[2];

  // Address decode
  wire logic hit_gain = (reg_req_in.addr == ADDR_STANDBY_GAIN);
  wire logic hit_thresh = (reg_req_in.addr == ADDR_STANDBY_THRESH);
  wire logic hit_base1 = (reg_req_in.addr == ADDR_BASELINE_CH1);
  wire logic hit_base2 = (reg_req_in.addr == ADDR_BASELINE_CH2);
  wire logic hit_base3 = (reg_req_in.addr == ADDR_BASELINE_CH3);
  wire logic hit_style = (reg_req_in.addr == ADDR_DRIVE_STYLE);
  wire logic hit_link = (reg_req_in.addr == ADDR_LAMP_LINK);
  wire logic hit_pol = (reg_req_in.addr == ADDR_LAMP_POLARITY);

  // Write strobes; baseline offsets have none, so writes there are dropped
  wire logic wr_gain = reg_req_in.wr & hit_gain;
  wire logic wr_thresh = reg_req_in.wr & hit_thresh;
  wire logic wr_style = reg_req_in.wr & hit_style;
  wire logic wr_link = reg_req_in.wr & hit_link;
  wire logic wr_pol = reg_req_in.wr & hit_pol;

  // Upper write bits are discarded by the part-selects
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      standby_gain_code_reg <= RST_STANDBY_GAIN;
    end else if (wr_gain) begin
      standby_gain_code_reg <= reg_req_in.wdata[2:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      standby_thresh_reg <= RST_STANDBY_THRESH;
    end else if (wr_thresh) begin
      standby_thresh_reg <= reg_req_in.wdata[6:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      drive_style_reg <= RST_DRIVE_STYLE;
    end else if (wr_style) begin
      drive_style_reg <= reg_req_in.wdata[CH_N-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      lamp_link_reg <= RST_LAMP_LINK;
    end else if (wr_link) begin
      lamp_link_reg <= reg_req_in.wdata[CH_N-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      lamp_polarity_reg <= RST_LAMP_POLARITY;
    end else if (wr_pol) begin
      lamp_polarity_reg <= reg_req_in.wdata[CH_N-1:0];
    end
  end

  // Recalibration, baseline presentation and standby detection per input
  wire logic [COUNT_W-1:0] baseline [CH_N];
  wire logic [7:0] baseline_view [CH_N];
  wire logic [CH_N-1:0] touch_next;
  wire logic [CH_N-1:0] actuate;
  // Multiplier 128x at code 0 halving to 1x at code 7, as a left shift
  wire logic [2:0] gain_shift = GAIN_CODE_MAX - standby_gain_code_reg;
  wire logic [14:0] thresh_wide = {8'h00, standby_thresh_reg};

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      wire logic [7:0] delta = delta_count_in[g*8 +: 8];
      wire logic [14:0] delta_scaled = {7'h00, delta} << gain_shift;
      wire logic over = delta_scaled > thresh_wide;
      wire logic [COUNT_W-1:0] shifted = baseline[g] >> base_shift_in;
      wire logic sb_touch = delta_valid_in[g] ? over : touch_reg[g];
      wire logic sb_next = standby_enable_in[g] ? sb_touch : 1'b0;
      lamp_ctrl_s ctrl;

      baseline_recal u_recal (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .sample_valid_in(count_valid_in[g]),
        .count_in(count_in[g*COUNT_W +: COUNT_W]),
        .baseline_out(baseline[g])
      );

      assign baseline_view[g] = shifted[7:0];
      assign touch_next[g] = standby_mode_in ? sb_next : active_touch_in[g];
      // Link selects touch and ignores host drive; otherwise host drive only
      assign actuate[g] = lamp_link_reg[g] ? touch_reg[g] : lamp_host_drive_in[g];
      assign ctrl = '{
        style: drive_style_reg[g],
        polarity: lamp_polarity_reg[g],
        actuate: actuate[g]
      };

      lamp_pin_driver u_pin (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .ctrl_in(ctrl),
        .pin_out(lamp_pin_out[g]),
        .pin_oe_out(lamp_pin_oe_out[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      touch_reg <= '0;
    end else begin
      touch_reg <= touch_next;
    end
  end

  // Read data selection; unused upper bits are zero-filled
  wire logic [7:0] rd_gain = {5'h00, standby_gain_code_reg};
  wire logic [7:0] rd_thresh = {1'b0, standby_thresh_reg};
  wire logic [7:0] rd_style = {5'h00, lamp3_drive_style, lamp2_drive_style, lamp1_drive_style};
  wire logic [7:0] rd_link = {5'h00, link_touch3_lamp3, link_touch2_lamp2, link_touch1_lamp1};
  wire logic [7:0] rd_pol = {5'h00, lamp3_polarity, lamp2_polarity, lamp1_polarity};

  wire logic [7:0] rd_sel =
    hit_gain ? rd_gain :
    hit_thresh ? rd_thresh :
    hit_base1 ? baseline_view[0] :
    hit_base2 ? baseline_view[1] :
    hit_base3 ? baseline_view[2] :
    hit_style ? rd_style :
    hit_link ? rd_link :
    hit_pol ? rd_pol :
    RD_UNMAPPED;

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (reg_req_in.rd) begin
      rdata_reg <= rd_sel;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign touch_out = touch_reg;

endmodule
`default_nettype wire

// *** verif/touch_cfg_checker.sv ***
// Port-level checks for the touch and lamp register slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module touch_cfg_checker
  import touch_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Watched ports
  input wire reg_req_s reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic standby_mode_in,
  input wire logic [CH_N-1:0] standby_enable_in,
  input wire logic [CH_N-1:0] active_touch_in,
  input wire logic [CH_N-1:0] delta_valid_in,
  input wire logic [CH_N*8-1:0] delta_count_in,
  input wire logic [CH_N-1:0] touch_out,
  input wire logic [CH_N-1:0] lamp_pin_out,
  input wire logic [CH_N-1:0] lamp_pin_oe_out
);
  logic [1:0] up_reg;
  logic live;
  logic sb0;
  assign live = up_reg == 2'h3;
  assign sb0 = live && standby_mode_in && standby_enable_in[0];
  // Skips the internal reset synchroniser
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_reg <= 2'h0;
    end else if (!live) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  unmapped_read_a: assert property (
    live && reg_req_in.rd && reg_req_in.addr == 8'h60 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  gain_read_a: assert property (
    live && reg_req_in.rd && reg_req_in.addr == 8'h42 |=> reg_rdata_out[7:3] == 5'h00)
    else $error("gain upper bits set");
  thresh_read_a: assert property (
    live && reg_req_in.rd && reg_req_in.addr == 8'h43 |=> !reg_rdata_out[7])
    else $error("threshold bit 7 set");
  od_release_a: assert property (
    (lamp_pin_out & ~lamp_pin_oe_out) == 3'h0)
    else $error("released pin shows high");
  stby_off_a: assert property (
    live && standby_mode_in |=> (touch_out & ~$past(standby_enable_in)) == 3'h0)
    else $error("disabled input touched");
  active_follow_a: assert property (
    live && !standby_mode_in |=> touch_out == $past(active_touch_in))
    else $error("touch not following active result");
  stby_hold_a: assert property (
    sb0 && !delta_valid_in[0] |=> $stable(touch_out[0]))
    else $error("touch moved without delta");
  zero_delta_a: assert property (
    sb0 && delta_valid_in[0] && delta_count_in[7:0] == 8'h00 |=> !touch_out[0])
    else $error("zero delta touched");
  full_delta_a: assert property (
    sb0 && delta_valid_in[0] && delta_count_in[7:0] == 8'hFF |=> touch_out[0])
    else $error("full delta missed");
endmodule
bind touch_standby_led_config touch_cfg_checker chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .standby_mode_in(standby_mode_in),
  .standby_enable_in(standby_enable_in), .active_touch_in(active_touch_in),
  .delta_valid_in(delta_valid_in), .delta_count_in(delta_count_in), .touch_out(touch_out),
  .lamp_pin_out(lamp_pin_out), .lamp_pin_oe_out(lamp_pin_oe_out));
`default_nettype wire

// *** verif/reg_port_host.sv ***
// Model of the serial-port logic that issues register requests.
// Assumes one-cycle request pulses taken at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module reg_port_host
  import touch_cfg_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Request toward the register port
  output var reg_req_s req_out
);
  initial req_out = '0;
  // Launch after a falling edge, drop at the taking edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '0;
  endtask
endmodule
`default_nettype wire

// *** verif/test_touch_standby_led_config.sv ***
// Self-checking bench for the touch and lamp register slice.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
`default_nettype none
module test_touch_standby_led_config
  import touch_cfg_pkg::*;
;
  logic clk_in = 1'b0, rst_b_in = 1'b0, stby = 1'b0, rd_d = 1'b0, snap = 1'b0;
  reg_req_s req;
  logic [7:0] rdata;
  logic [2:0] sb_en = '0, act = '0, dv = '0, cv = '0, hdrv = '0, touch, pin, oe;
  logic [2:0] sty, lnk, pol;
  logic [23:0] dcnt = '0;
  logic [47:0] cnt = '0;
  logic [3:0] shift = '0;
  logic [31:0] seed = 32'd95283, r;
  logic [8:0] exp_q[$];
  int bad_count = 0, n_checks = 0;
  logic [7:0] at [9] = '{8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h71, 8'h72, 8'h73, 8'h60};
  logic [7:0] rt [9] = '{8'h02, 8'h40, 8'hC8, 8'hC8, 8'hC8, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ft [9] = '{8'h07, 8'h7F, 8'hC8, 8'hC8, 8'hC8, 8'h07, 8'h07, 8'h07, 8'h00};
  reg_port_host far (.clk_in(clk_in), .req_out(req));
  touch_standby_led_config dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .standby_mode_in(stby), .standby_enable_in(sb_en),
    .active_touch_in(act), .delta_valid_in(dv), .delta_count_in(dcnt), .count_valid_in(cv),
    .count_in(cnt), .base_shift_in(shift), .lamp_host_drive_in(hdrv), .touch_out(touch),
    .lamp_pin_out(pin), .lamp_pin_oe_out(oe));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [8:0] pins(input logic [2:0] t);
    logic [2:0] lv;
    lv = ~(pol ^ ((lnk & t) | (~lnk & hdrv)));
    return {t, lv & sty, sty | ~lv};
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] want);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    far.access(1'b0, a, 8'h00);
  endtask
  task automatic cfg(input logic [2:0] s, input logic [2:0] l, input logic [2:0] p);
    far.access(1'b1, 8'h71, {5'h00, s});
    far.access(1'b1, 8'h72, {5'h00, l});
    far.access(1'b1, 8'h73, {5'h00, p});
    {sty, lnk, pol} = {s, l, p};
  endtask
  task automatic look(input logic [2:0] t);
    repeat (2) @(negedge clk_in);
    exp_q.push_back(pins(t));
    snap <= 1'b1;
    @(negedge clk_in);
    snap <= 1'b0;
  endtask
  task automatic give_verdict();
    check(9'(exp_q.size()), 9'h000);
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_in) rd_d <= req.rd;
  always @(negedge clk_in) begin
    if (rd_d || snap) begin
      check(rd_d ? {1'b0, rdata} : {touch, pin, oe}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_in);
    for (int i = 0; i < 9; i++) rd(at[i], rt[i]);
    for (int i = 0; i < 9; i++) far.access(1'b1, at[i], 8'hFF);
    for (int i = 0; i < 9; i++) rd(at[i], ft[i]);
    cfg(3'h0, 3'h0, 3'h0);
    far.access(1'b1, 8'h43, 8'h40);
    @(negedge clk_in);
    stby = 1'b1;
    sb_en = 3'h1;
    for (int g = 0; g < 8; g++) begin
      far.access(1'b1, 8'h42, 8'(g));
      for (int k = 0; k < 3; k++) begin
        @(negedge clk_in);
        dcnt[7:0] = k == 2 ? 8'hFF : 8'(8'h40 >> (7 - g)) + 8'(k);
        dv = 3'h1;
        @(negedge clk_in);
        dv = 3'h0;
        look({2'b00, k != 0});
      end
    end
    stby = 1'b0;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      cfg(r[2:0], r[5:3], r[8:6]);
      @(negedge clk_in);
      hdrv = r[11:9];
      act = r[14:12];
      look(act);
    end
    r = rnd();
    cnt = {r[15:0], r[31:16], r[23:8]};
    cv = 3'h7;
    repeat (255) @(negedge clk_in);
    cv = 3'h0;
    rd(8'h51, 8'hC8);
    @(negedge clk_in);
    cv = 3'h7;
    @(negedge clk_in);
    cv = 3'h0;
    for (int n = 0; n < 3; n++) rd(8'(8'h50 + n), cnt[16*n +: 8]);
    @(negedge clk_in);
    shift = 4'h8;
    for (int n = 0; n < 3; n++) rd(8'(8'h50 + n), cnt[16*n+8 +: 8]);
    repeat (2) @(negedge clk_in);
    give_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
